//--- core/ocs_pkg.sv
// package: shared constants and types of the output channel supervisor
package ocs_pkg;
	localparam int unsigned OCS_NCH = 24;
	localparam int unsigned OCS_CLK_HZ = 200000000;
	localparam int unsigned OCS_TICK_MS = 1;
	localparam int unsigned OCS_CYC_PER_MS = OCS_CLK_HZ / 1000 * OCS_TICK_MS;
	localparam int unsigned OCS_OC_QUAL_MS = 50;
	localparam int unsigned OCS_OC_OFF_S = 5;
	localparam int unsigned OCS_OC_OFF_MS = OCS_OC_OFF_S * 1000;
	localparam int unsigned OCS_SLOW_MS = 600;
	localparam int unsigned OCS_SHORT_MS = 200;
	localparam int unsigned OCS_TRIPLE_MS = 3 * OCS_SHORT_MS + OCS_SLOW_MS;
	localparam int unsigned OCS_SLOW_PER_MS = 2 * OCS_SLOW_MS;
	localparam int unsigned OCS_LAMP_MS = 1000;
	localparam int unsigned OCS_MS_W = 16;
	// offsets of the status, mask, control, state and overcurrent channel registers
	localparam logic [3:0] OCS_A_STAT = 4'h0;
	localparam logic [3:0] OCS_A_MASK = 4'h1;
	localparam logic [3:0] OCS_A_CTRL = 4'h2;
	localparam logic [3:0] OCS_A_STATE = 4'h3;
	localparam logic [3:0] OCS_A_OCHAN = 4'h4;
	// interrupt status bit positions
	localparam int unsigned OCS_IRQ_OC = 0;
	localparam int unsigned OCS_IRQ_LINE = 1;
	localparam int unsigned OCS_IRQ_MOD = 2;
	localparam int unsigned OCS_IRQ_BUS = 3;
	localparam int unsigned OCS_IRQ_W = 4;
	// control register fields
	localparam int unsigned OCS_C_LINEMON = 0;
	localparam int unsigned OCS_C_NORETRY = 1;
	localparam logic [31:0] OCS_CTRL_RST = 32'h0000_0000;
	typedef enum logic [5:0] {
		OCS_ST_INIT = 6'h01,
		OCS_ST_RUN = 6'h02,
		OCS_ST_STOP_VALID = 6'h04,
		OCS_ST_STOP_INVALID = 6'h08,
		OCS_ST_FW_LOAD = 6'h10,
		OCS_ST_LOCKED = 6'h20
	} ocs_mod_state_t;
	typedef struct packed {
		logic run;
		logic error;
		logic stop;
		logic init;
		logic field;
		logic [OCS_NCH-1:0] chan;
	} ocs_leds_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ocs_bus_req_t;
endpackage

//--- core/ocs_tick_gen.sv
// millisecond tick and blink phase generator
`timescale 1ns/1ps
`default_nettype none
module ocs_tick_gen #(
	parameter int unsigned CYC_PER_MS = 200000
) (
	input wire logic clk, // module clock
	input wire logic rst_n, // synchronous-copy reset, active low
	output logic ms_tick, // one-cycle pulse each millisecond
	output logic slow_blink, // 600 ms on, 600 ms off
	output logic triple_pulse_blink // on-off-on then long off
);
	import ocs_pkg::*;
	logic [31:0] div_reg;
	logic [OCS_MS_W-1:0] slow_reg;
	logic [OCS_MS_W-1:0] trip_reg;
	wire div_wrap = (div_reg == CYC_PER_MS - 1);
	wire slow_wrap = (slow_reg == OCS_MS_W'(OCS_SLOW_PER_MS - 1));
	wire trip_wrap = (trip_reg == OCS_MS_W'(OCS_TRIPLE_MS - 1));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 32'h0;
			slow_reg <= '0;
			trip_reg <= '0;
			ms_tick <= 1'b0;
		end else begin
			div_reg <= div_wrap ? 32'h0 : div_reg + 32'h1;
			ms_tick <= div_wrap;
			if (ms_tick) begin
				slow_reg <= slow_wrap ? '0 : slow_reg + 1'b1;
				trip_reg <= trip_wrap ? '0 : trip_reg + 1'b1;
			end
		end
	end
	assign slow_blink = (slow_reg < OCS_MS_W'(OCS_SLOW_MS));
	assign triple_pulse_blink = (trip_reg < OCS_MS_W'(OCS_SHORT_MS)) ||
		((trip_reg >= OCS_MS_W'(2 * OCS_SHORT_MS)) &&
		(trip_reg < OCS_MS_W'(3 * OCS_SHORT_MS)));
endmodule
`default_nettype wire

//--- core/ocs_chan.sv
// one output channel: switches, overcurrent retry, fault state
`timescale 1ns/1ps
`default_nettype none
module ocs_chan #(
	parameter int unsigned QUAL_MS = 50,
	parameter int unsigned OFF_MS = 5000
) (
	input wire logic clk, // module clock
	input wire logic rst_n, // reset, active low
	input wire logic ms_tick, // millisecond enable
	input wire logic cmd_on, // commanded value from the bus
	input wire logic [2:0] bus_open, // bus opens each switch
	input wire logic [2:0] wd_open, // watchdog opens each switch
	input wire logic kill, // module-level or bus loss shutdown
	input wire logic over_i, // overcurrent above threshold
	input wire logic mismatch, // readback differs from expected
	input wire logic line_fault, // qualified open or short circuit
	input wire logic no_retry, // user program blocks re-enable
	output logic [2:0] sw_close, // the three series switches
	output logic energized, // channel output live
	output logic faulty, // channel in fault
	output logic oc_event // pulse on overcurrent trip
);
	import ocs_pkg::*;
	logic [OCS_MS_W-1:0] qual_reg;
	logic [OCS_MS_W-1:0] off_reg;
	logic oc_off_reg;
	logic mis_reg;
	wire qual_done = over_i && energized && (qual_reg == OCS_MS_W'(QUAL_MS - 1)) && ms_tick;
	wire off_done = oc_off_reg && !no_retry && (off_reg == OCS_MS_W'(OFF_MS - 1)) && ms_tick;
	wire chan_block = oc_off_reg || mis_reg || kill;
	assign sw_close = {3{cmd_on && !chan_block}} & ~bus_open & ~wd_open;
	assign energized = &sw_close;
	assign faulty = oc_off_reg || mis_reg || line_fault;
	assign oc_event = qual_done;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qual_reg <= '0;
			off_reg <= '0;
			oc_off_reg <= 1'b0;
			mis_reg <= 1'b0;
		end else begin
			if (!over_i || !energized)
				qual_reg <= '0;
			else if (ms_tick)
				qual_reg <= qual_reg + 1'b1;
			// retry every 5 s while fault stays, unless no_retry blocks it
			if (qual_done) begin
				oc_off_reg <= 1'b1;
				off_reg <= '0;
			end else if (off_done) begin
				oc_off_reg <= 1'b0;
			end else if (oc_off_reg && ms_tick && off_reg != OCS_MS_W'(OFF_MS - 1)) begin
				off_reg <= off_reg + 1'b1;
			end
			// mismatch latches safe state until command drops
			if (mismatch)
				mis_reg <= 1'b1;
			else if (!cmd_on)
				mis_reg <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- core/ocs_top.sv
// output channel supervisor top: channels, registers, indicators
// Summary of operation
// - each channel energizes only when all three series switches are closed
// - bus command or watchdog alone can open any switch of a channel
// - an output differing from its expected value is forced de-energized
// - channel fault drops one channel; module fault drops all 24; a line fault flags its channel but does not drop it
// - loss of the system bus de-energizes every output
// - red error lamp lit on internal fault or firmware load failure
// - overcurrent lasting 50 ms switches channel off for 5 s then on
// - retry cycle repeats while overcurrent stays unless user blocks retry
// - line monitoring, when enabled, checks open and short circuit each channel
// - after power-up all lamps light together briefly
// - slow blink is 600 ms on, 600 ms off
// - triple pulse blink is 200 on, 200 off, 200 on, 600 off
// - green run lamp steady in run, slow blink in firmware load
// - yellow stop lamp steady valid stop, slow blink invalid or load
// - yellow init lamp steady in init, slow blink when locked
// - channel lamp steady energized, triple pulse when faulty, else dark
// - red field lamp triple pulse while any channel has field fault
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ocs_top #(
	parameter int unsigned NCH = ocs_pkg::OCS_NCH,
	parameter int unsigned CYC_PER_MS = ocs_pkg::OCS_CYC_PER_MS,
	parameter int unsigned QUAL_MS = ocs_pkg::OCS_OC_QUAL_MS,
	parameter int unsigned OFF_MS = ocs_pkg::OCS_OC_OFF_MS,
	parameter int unsigned LAMP_MS = ocs_pkg::OCS_LAMP_MS
) (
	input wire logic core_clk, // 200 MHz module clock
	input wire logic rst_n, // power-on reset, active low
	input wire logic [3:0] reg_addr, // register index
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after read
	input wire logic [NCH-1:0] cmd_on, // expected output values from bus
	input wire logic [NCH-1:0] bus_open_a, // bus opens switch a
	input wire logic [NCH-1:0] bus_open_b, // bus opens switch b
	input wire logic [NCH-1:0] bus_open_c, // bus opens switch c
	input wire logic [NCH-1:0] wd_open_a, // watchdog opens switch a
	input wire logic [NCH-1:0] wd_open_b, // watchdog opens switch b
	input wire logic [NCH-1:0] wd_open_c, // watchdog opens switch c
	input wire logic [NCH-1:0] readback, // sensed output level
	input wire logic [NCH-1:0] over_i, // current above 0.75 A
	input wire logic [NCH-1:0] open_circuit_check, // comparator: open line
	input wire logic [NCH-1:0] short_circuit_check, // comparator: shorted line
	input wire logic bus_ok, // system bus link alive
	input wire logic module_fault, // module-level self-test fault
	input wire logic fw_load_fail, // firmware load failed
	input wire ocs_pkg::ocs_mod_state_t mod_state, // module operating state
	output logic [NCH-1:0] sw_a, // switch a close
	output logic [NCH-1:0] sw_b, // switch b close
	output logic [NCH-1:0] sw_c, // switch c close
	output logic [NCH-1:0] chan_live, // channel energized
	output ocs_pkg::ocs_leds_t leds, // all indicator lamps
	output logic irq // level interrupt
);
	import ocs_pkg::*;
	logic rst_s1_reg;
	logic rst_s2_reg;
	logic ms_tick;
	logic slow_blink;
	logic triple_pulse_blink;
	logic [OCS_IRQ_W-1:0] stat_reg;
	logic [OCS_IRQ_W-1:0] mask_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] rdata_reg;
	logic [NCH-1:0] oc_chan_reg;
	logic [OCS_MS_W-1:0] lamp_reg;
	logic bus_ok_reg;
	logic [NCH-1:0] ener;
	logic [NCH-1:0] faulty;
	logic [NCH-1:0] oc_ev;
	logic [NCH-1:0] line_fault;
	logic [NCH-1:0] line_reg;

	// reset released through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	wire srst_n = rst_s2_reg;

	ocs_tick_gen #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_tick (
		.clk(core_clk),
		.rst_n(srst_n),
		.ms_tick(ms_tick),
		.slow_blink(slow_blink),
		.triple_pulse_blink(triple_pulse_blink)
	);

	wire line_en = ctrl_reg[OCS_C_LINEMON];
	wire no_retry = ctrl_reg[OCS_C_NORETRY];
	// line checks only when enabled; thresholds live in the comparators
	assign line_fault = line_en ? (open_circuit_check | short_circuit_check) : '0;
	// bus loss and module fault drop every channel
	wire kill_all = !bus_ok || module_fault;
	wire [NCH-1:0] mismatch = cmd_on ^ readback;
	wire [NCH-1:0] mis_live = mismatch & chan_live;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			// per-channel faults stay in their own channel
			ocs_chan #(
				.QUAL_MS(QUAL_MS),
				.OFF_MS(OFF_MS)
			) u_ch (
				.clk(core_clk),
				.rst_n(srst_n),
				.ms_tick(ms_tick),
				.cmd_on(cmd_on[g]),
				.bus_open({bus_open_c[g], bus_open_b[g], bus_open_a[g]}),
				.wd_open({wd_open_c[g], wd_open_b[g], wd_open_a[g]}),
				.kill(kill_all),
				.over_i(over_i[g]),
				.mismatch(mis_live[g]),
				.line_fault(line_fault[g]),
				.no_retry(no_retry),
				.sw_close({sw_c[g], sw_b[g], sw_a[g]}),
				.energized(ener[g]),
				.faulty(faulty[g]),
				.oc_event(oc_ev[g])
			);
		end
	endgenerate
	assign chan_live = ener;

	// event sources; set wins over write-one-to-clear
	wire [OCS_IRQ_W-1:0] ev;
	assign ev[OCS_IRQ_OC] = |oc_ev;
	assign ev[OCS_IRQ_LINE] = |(line_fault & ~line_reg);
	assign ev[OCS_IRQ_MOD] = module_fault;
	assign ev[OCS_IRQ_BUS] = bus_ok_reg && !bus_ok;

	wire wr_stat = reg_wr && reg_addr == OCS_A_STAT;
	wire wr_mask = reg_wr && reg_addr == OCS_A_MASK;
	wire wr_ctrl = reg_wr && reg_addr == OCS_A_CTRL;
	wire [OCS_IRQ_W-1:0] w1c = wr_stat ? reg_wdata[OCS_IRQ_W-1:0] : '0;

	always_ff @(posedge core_clk or negedge srst_n) begin
		if (!srst_n) begin
			stat_reg <= '0;
			mask_reg <= '0;
			ctrl_reg <= OCS_CTRL_RST;
			line_reg <= '0;
			bus_ok_reg <= 1'b0;
			oc_chan_reg <= '0;
		end else begin
			stat_reg <= (stat_reg & ~w1c) | ev;
			line_reg <= line_fault;
			bus_ok_reg <= bus_ok;
			if (wr_mask)
				mask_reg <= reg_wdata[OCS_IRQ_W-1:0];
			if (wr_ctrl)
				ctrl_reg <= reg_wdata;
			oc_chan_reg <= (oc_chan_reg | oc_ev) & ~((reg_wr && reg_addr == OCS_A_OCHAN) ?
				reg_wdata[NCH-1:0] : '0) | oc_ev;
		end
	end
	assign irq = |(stat_reg & mask_reg);

	// read mux; unmapped indices read zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (reg_addr)
			OCS_A_STAT: rd_mux = {{(32-OCS_IRQ_W){1'b0}}, stat_reg};
			OCS_A_MASK: rd_mux = {{(32-OCS_IRQ_W){1'b0}}, mask_reg};
			OCS_A_CTRL: rd_mux = ctrl_reg;
			OCS_A_STATE: rd_mux = {26'h0, mod_state};
			OCS_A_OCHAN: rd_mux = {{(32-NCH){1'b0}}, oc_chan_reg};
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge core_clk or negedge srst_n) begin
		if (!srst_n)
			rdata_reg <= 32'h0;
		else
			rdata_reg <= reg_rd ? rd_mux : 32'h0;
	end
	assign reg_rdata = rdata_reg;

	always_ff @(posedge core_clk or negedge srst_n) begin
		if (!srst_n)
			lamp_reg <= '0;
		else if (ms_tick && lamp_reg != OCS_MS_W'(LAMP_MS))
			lamp_reg <= lamp_reg + 1'b1;
	end
	wire lamp_test = (lamp_reg != OCS_MS_W'(LAMP_MS));

	// lamp decode, registered so the lamps never glitch
	ocs_leds_t led_next;
	always_comb begin
		led_next = '0;
		case (mod_state)
			OCS_ST_RUN: led_next.run = 1'b1;
			OCS_ST_FW_LOAD: led_next.run = slow_blink;
			default: led_next.run = 1'b0;
		endcase
		case (mod_state)
			OCS_ST_STOP_VALID: led_next.stop = 1'b1;
			OCS_ST_STOP_INVALID: led_next.stop = slow_blink;
			OCS_ST_FW_LOAD: led_next.stop = slow_blink;
			default: led_next.stop = 1'b0;
		endcase
		case (mod_state)
			OCS_ST_INIT: led_next.init = 1'b1;
			OCS_ST_LOCKED: led_next.init = slow_blink;
			default: led_next.init = 1'b0;
		endcase
		// error lamp steady on fault, slow blink on load failure
		led_next.error = module_fault || (fw_load_fail && slow_blink);
		led_next.field = (|(line_fault | (faulty & over_i))) && triple_pulse_blink;
		led_next.chan = (ener & ~faulty) | (faulty & {NCH{triple_pulse_blink}});
		if (lamp_test)
			led_next = '1;
	end
	always_ff @(posedge core_clk or negedge srst_n) begin
		if (!srst_n)
			leds <= '0;
		else
			leds <= led_next;
	end
endmodule
`default_nettype wire

//--- tb/ocs_top_chk_assertions.sv
// checker: safety and lamp properties seen at the supervisor top ports
`timescale 1ns/1ps
`default_nettype none
module ocs_top_chk #(
	parameter int unsigned NCH = 24,
	parameter int unsigned CYC_PER_MS = 4,
	parameter int unsigned QUAL_MS = 3,
	parameter int unsigned LAMP_MS = 5
) (
	input wire logic core_clk, // clock
	input wire logic rst_n, // reset, active low
	input wire logic [NCH-1:0] cmd_on, // expected values
	input wire logic bus_ok, // bus alive
	input wire logic module_fault, // module fault
	input wire ocs_pkg::ocs_mod_state_t mod_state, // module state
	input wire logic [NCH-1:0] over_i, // overcurrent
	input wire logic [NCH-1:0] bus_open_a, // bus opens switch a
	input wire logic [NCH-1:0] wd_open_a, // watchdog opens switch a
	input wire logic [NCH-1:0] sw_a, // switch a
	input wire logic [NCH-1:0] sw_b, // switch b
	input wire logic [NCH-1:0] sw_c, // switch c
	input wire logic [NCH-1:0] chan_live, // live channels
	input wire ocs_pkg::ocs_leds_t leds // lamps
);
	import ocs_pkg::*;
	localparam int DONE_AT = LAMP_MS * CYC_PER_MS + 8;
	localparam int OC_MAX = (QUAL_MS + 1) * CYC_PER_MS + 3;
	int age;
	int oc_len;
	logic done;
	assign done = age > DONE_AT;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// lamp states other than the lamp test itself are only judged once the power-up lamp test is over
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			age <= 0;
			oc_len <= 0;
		end else begin
			age <= done ? age : age + 1;
			oc_len <= (chan_live[0] && over_i[0]) ? oc_len + 1 : 0;
		end
	end
	AST_SERIES:
	assert property (chan_live == (sw_a & sw_b & sw_c)) else $error("live without all switches");
	AST_SW_OPEN:
	assert property (((bus_open_a | wd_open_a) & sw_a) == '0) else $error("switch a closed while opened");
	AST_CMD_OFF:
	assert property ((chan_live & ~cmd_on) == '0) else $error("live without command");
	AST_MOD_KILL:
	assert property (module_fault |-> chan_live == '0) else $error("live in module fault");
	AST_BUS_LOSS:
	assert property (!bus_ok |-> chan_live == '0) else $error("live after bus loss");
	AST_ERR_LAMP:
	assert property ((done && module_fault) [*3] |-> leds.error) else $error("error lamp dark");
	AST_OC_TRIP:
	assert property (oc_len <= OC_MAX) else $error("overcurrent not tripped in time");
	AST_LAMP_TEST:
	assert property ($rose(rst_n) |-> ##[1:6] (&leds)) else $error("no lamp test");
	AST_RUN_LAMP:
	assert property ((done && mod_state == OCS_ST_RUN) [*3] |-> leds.run && !leds.init)
		else $error("run lamps wrong");
	AST_INIT_LAMP:
	assert property ((done && mod_state == OCS_ST_INIT) [*3] |-> leds.init && !leds.run)
		else $error("init lamps wrong");
endmodule
bind ocs_top ocs_top_chk #(.NCH(NCH), .CYC_PER_MS(CYC_PER_MS), .QUAL_MS(QUAL_MS),
	.LAMP_MS(LAMP_MS)) chk (.*);
`default_nettype wire

//--- tb/ocs_proc_model.sv
// far-side model: processors reading back the output stage
`timescale 1ns/1ps
`default_nettype none
module ocs_proc_model (
	input wire logic [23:0] chan_live, // live outputs
	input wire logic [23:0] flip, // channels whose readback is made wrong
	output logic [23:0] readback // sensed levels back to the supervisor
);
	assign readback = chan_live ^ flip;
endmodule
`default_nettype wire

//--- tb/tb.sv
// bench: supervisor channels, faults, registers and lamps
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ocs_pkg::*;
	localparam int C = 4;
	localparam int Q = 3;
	localparam int F = 10;
	localparam int N = 1300 * C;
	logic core_clk = 0;
	logic rst_n = 0;
	logic [3:0] ad = '0;
	logic [31:0] wd = '0;
	logic wr_s = 0;
	logic rd_s = 0;
	logic bus_ok = 1;
	logic mf = 0;
	logic fw = 0;
	logic irq;
	logic [31:0] rdat;
	logic [23:0] cmd = '0, flip = '0, ovr = '0, opc = '0, shc = '0;
	logic [23:0] rb, sa, sb, sc, live;
	logic [23:0] op [6] = '{default: '0};
	ocs_mod_state_t st = OCS_ST_INIT;
	ocs_leds_t leds;
	int miscompares = 0;
	int n_tests = 0;
	always #2.5 core_clk = ~core_clk;
	ocs_top #(.CYC_PER_MS(C), .QUAL_MS(Q), .OFF_MS(F), .LAMP_MS(5)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(ad), .reg_wdata(wd),
		.reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .cmd_on(cmd),
		.bus_open_a(op[0]), .bus_open_b(op[1]), .bus_open_c(op[2]),
		.wd_open_a(op[3]), .wd_open_b(op[4]), .wd_open_c(op[5]), .readback(rb),
		.over_i(ovr), .open_circuit_check(opc), .short_circuit_check(shc),
		.bus_ok(bus_ok), .module_fault(mf), .fw_load_fail(fw), .mod_state(st),
		.sw_a(sa), .sw_b(sb), .sw_c(sc), .chan_live(live), .leds(leds), .irq(irq));
	ocs_proc_model pm (.chan_live(live), .flip(flip), .readback(rb));
	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		ad <= a;
		wd <= d;
		wr_s <= 1;
		@(posedge core_clk);
		wr_s <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk);
		ad <= a;
		rd_s <= 1;
		@(posedge core_clk);
		rd_s <= 0;
		#1 chk(rdat, e);
	endtask
	// bounded wait for channel level; running out ends the run
	task automatic wl(input int ch, input logic v, input int lim, output int n);
		n = 0;
		while (live[ch] !== v) begin
			@(posedge core_clk);
			#1 n++;
			if (n > lim) begin
				miscompares++;
				stop_test();
			end
		end
	endtask
	function automatic logic [1:0] cls(input int k);
		if (k == 0) return 2'd0;
		if (k == N) return 2'd1;
		if (k >= 550 * C && k <= 750 * C) return 2'd2;
		return 2'd3;
	endfunction
	task automatic t_pwr();
		@(posedge core_clk);
		rst_n <= 1;
		repeat (4) @(posedge core_clk);
		#1 chk(32'(leds), 32'h1fff_ffff);
		repeat (5 * C + 8) @(posedge core_clk);
	endtask
	task automatic t_sw();
		@(posedge core_clk);
		cmd <= '1;
		repeat (3) @(posedge core_clk);
		#1 chk(live, 24'hff_ffff);
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			op[i] <= 24'h1 << (i * 3);
			#1 chk(live, 24'(~(24'h1 << (i * 3))));
			chk({sc[3 * i], sb[3 * i], sa[3 * i]}, 3'h7 & ~(3'h1 << (i % 3)));
			@(posedge core_clk);
			op[i] <= '0;
		end
	endtask
	task automatic t_mis();
		@(posedge core_clk);
		flip <= 24'h20;
		repeat (3) @(posedge core_clk);
		#1 chk(live, 24'hff_ffdf);
		@(posedge core_clk);
		flip <= '0;
		repeat (3) @(posedge core_clk);
		#1 chk(live, 24'hff_ffdf);
		@(posedge core_clk);
		cmd[5] <= 0;
		@(posedge core_clk);
		cmd[5] <= 1;
		repeat (3) @(posedge core_clk);
		#1 chk(live, 24'hff_ffff);
	endtask
	task automatic t_flt();
		wr(OCS_A_MASK, 32'hc);
		@(posedge core_clk);
		mf <= 1;
		#1 chk(live, 24'h0);
		repeat (4) @(posedge core_clk);
		#1 chk(leds.error, 1'b1);
		chk(irq, 1'b1);
		@(posedge core_clk);
		mf <= 0;
		bus_ok <= 0;
		#1 chk(live, 24'h0);
		@(posedge core_clk);
		bus_ok <= 1;
		rd(OCS_A_STAT, 32'hc);
		wr(OCS_A_STAT, 32'h4);
		wr(OCS_A_MASK, 32'h4);
		rd(OCS_A_STAT, 32'h8);
		chk(irq, 1'b0);
		wr(OCS_A_STAT, 32'h8);
		rd(OCS_A_STAT, 32'h0);
		chk(live, 24'hff_ffff);
	endtask
	task automatic t_oc();
		int n, f, k, g;
		@(posedge core_clk);
		ovr[0] <= 1;
		wl(0, 0, (Q + 2) * C, n);
		chk(n >= (Q - 1) * C, 1);
		wl(0, 1, (F + 2) * C, n);
		chk(n >= (F - 1) * C, 1);
		wl(0, 0, (Q + 2) * C, n);
		chk(live[23:1], 23'h7f_ffff);
		rd(OCS_A_STAT, 32'h1);
		rd(OCS_A_OCHAN, 32'h1);
		wr(OCS_A_CTRL, 32'h2);
		f = 0;
		k = 0;
		g = 0;
		repeat (N) begin
			@(posedge core_clk);
			#1 f += live[0];
			k += leds.field;
			g += leds.chan[0];
		end
		chk(f, 0);
		chk(k >= 350 * C && k <= 650 * C, 1);
		chk(g >= 350 * C && g <= 650 * C, 1);
		@(posedge core_clk);
		ovr[0] <= 0;
		wr(OCS_A_CTRL, 32'h0);
		wl(0, 1, (F + 2) * C, n);
		wr(OCS_A_STAT, 32'h1);
		wr(OCS_A_OCHAN, 32'h1);
		rd(OCS_A_OCHAN, 32'h0);
	endtask
	task automatic t_line();
		@(posedge core_clk);
		opc[7] <= 1;
		repeat (20 * C) @(posedge core_clk);
		rd(OCS_A_STAT, 32'h0);
		@(posedge core_clk);
		opc[7] <= 0;
		wr(OCS_A_CTRL, 32'h1);
		shc[8] <= 1;
		repeat (20 * C) @(posedge core_clk);
		rd(OCS_A_STAT, 32'h2);
		rd(4'hf, 32'h0);
	endtask
	task automatic t_lamps();
		ocs_mod_state_t s [7] = '{OCS_ST_INIT, OCS_ST_RUN, OCS_ST_STOP_VALID,
			OCS_ST_STOP_INVALID, OCS_ST_FW_LOAD, OCS_ST_LOCKED, OCS_ST_RUN};
		logic [7:0] e [7] = '{8'h04, 8'h40, 8'h10, 8'h20, 8'ha0, 8'h08, 8'h42};
		int c [4];
		for (int i = 0; i < 7; i++) begin
			@(posedge core_clk);
			st <= s[i];
			fw <= (i == 6);
			repeat (4) @(posedge core_clk);
			rd(OCS_A_STATE, 32'(s[i]));
			c = '{default: 0};
			repeat (N) begin
				@(posedge core_clk);
				#1 c[0] += leds.run === 1'b1;
				c[1] += leds.stop === 1'b1;
				c[2] += leds.init === 1'b1;
				c[3] += leds.error === 1'b1;
			end
			chk(cls(c[0]), e[i][7:6]);
			chk(cls(c[1]), e[i][5:4]);
			chk(cls(c[2]), e[i][3:2]);
			chk(cls(c[3]), e[i][1:0]);
		end
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		t_pwr();
		t_sw();
		t_mis();
		t_flt();
		t_oc();
		t_line();
		t_lamps();
		stop_test();
	end
endmodule
`default_nettype wire
